// >>> src/dcc_cfg.svh
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH
// register byte addresses on the axi4-lite bus
`define DCC_ADDR_ONE_CTRL 4'h0
`define DCC_ADDR_TWO_CTRL 4'h4
`define DCC_ADDR_SHARED 4'h8
`define DCC_ADDR_STATUS 4'hc
// control register field positions
`define DCC_CTL_ENABLE 7
`define DCC_CTL_OUTPUT 6
`define DCC_CTL_PIN_OE 5
`define DCC_CTL_POLARITY 4
`define DCC_CTL_SPEED 3
`define DCC_CTL_REFSEL 2
`define DCC_CTL_CHAN_HI 1
`define DCC_CTL_CHAN_LO 0
// shared register field positions
`define DCC_SH_MIRROR1 7
`define DCC_SH_MIRROR2 6
`define DCC_SH_RSRC1 5
`define DCC_SH_RSRC2 4
`define DCC_SH_HYS1 3
`define DCC_SH_HYS2 2
`define DCC_SH_SYNC1 1
`define DCC_SH_SYNC2 0
// reset values of the writable bits
`define DCC_CTL_RESET 8'h08
`define DCC_SH_RESET 8'h00
// axi response codes
`define DCC_RESP_OKAY 2'b00
`define DCC_RESP_SLVERR 2'b10
`endif

// >>> src/dcc_pkg.sv
package dcc_pkg;
    // per-comparator analog control bundle
    typedef struct packed {
        logic enable;
        logic pin_drive;
        logic speed_high;
        logic ref_to_pos;
        logic ref_from_fvr;
        logic hysteresis;
        logic [1:0] channel;
    } dcc_analog_t;
    // write-side bus phase
    typedef enum {
        DCC_WR_IDLE,
        DCC_WR_RESP
    } dcc_wr_state_t;
endpackage : dcc_pkg

// >>> src/dcc_cmp_path.sv
`include "dcc_cfg.svh"
// one comparator output path: polarity, optional timer-edge latch, mismatch latches
module dcc_cmp_path
    import dcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic raw_above,
    input wire logic enable,
    input wire logic polarity,
    input wire logic sync_mode,
    input wire logic tick_fall,
    input wire logic snap,
    output logic result,
    output logic change
);
    logic live;
    logic sync_r;
    logic ref_r;
    logic seen_r;

    // disabled comparator shows polarity level; enabled compares then inverts when polarity is set
    assign live = enable ? (raw_above ^ polarity) : polarity;

    // latch on every falling prescaled timer edge; sync mode only selects the latched value
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_r <= 1'b0;
        end else if (ce && tick_fall) begin
            sync_r <= live;
        end
    end

    assign result = sync_mode ? sync_r : live;

    // reference latch taken on register access, sample latch every cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ref_r <= 1'b0;
            seen_r <= 1'b0;
        end else if (ce) begin
            seen_r <= result;
            if (snap) begin
                ref_r <= result;
            end
        end
    end

    assign change = ref_r ^ seen_r;
endmodule : dcc_cmp_path

// >>> src/dcc_top.sv
// Functional notes
// - control bit 7 enables the register's own comparator
// - output bit follows comparison, polarity inverts
// - pin driven when oe, enabled, direction zero
// - speed bit resets one; zero means low-power
// - reference select routes reference to positive input
// - channel field picks one of four negatives
// - shared register mirrors both comparator outputs
// - shared register read leaves mismatch latches alone
// - reference source bit picks fixed or dac
// - hysteresis bits enable hysteresis, reset zero
// - sync mode latches output on falling timer edge
// - sync latch uses prescaled timer clock
// - timer counts rising, latch on falling edge
// - sync bit zero passes output through
// - analog-configured port pins read as zero
// - reference reaches comparator through two selections
// - mismatch between latches raises change flag
// - control register access refreshes reference latch
// - disabled comparator output equals polarity bit
// - reset returns all registers, comparators off
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`include "dcc_cfg.svh"
module dcc_top
    import dcc_pkg::*;
#(
    parameter int PORT_WIDTH = 8
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    // axi4-lite slave
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // analog comparator results (positive above negative)
    input wire logic CMP1_ABOVE,
    input wire logic CMP2_ABOVE,
    // prescaled timer clock sample and pin direction bits
    input wire logic TIMER_TICK,
    input wire logic CMP1_PORT_DIRECTION,
    input wire logic CMP2_PORT_DIRECTION,
    // port pin levels and analog select, port read value
    input wire logic [PORT_WIDTH-1:0] PORT_PINS,
    input wire logic [PORT_WIDTH-1:0] PORT_ANALOG,
    output logic [PORT_WIDTH-1:0] PORT_READ,
    // analog controls
    output dcc_analog_t CMP1_ANALOG,
    output dcc_analog_t CMP2_ANALOG,
    // comparator output pins
    output logic CMP1_PIN,
    output logic CMP1_PIN_OE_B,
    output logic CMP2_PIN,
    output logic CMP2_PIN_OE_B,
    // mismatch flags for the interrupt logic outside
    output logic CMP1_CHANGE,
    output logic CMP2_CHANGE
);
    // refuse port widths that the read path cannot hold
    if (PORT_WIDTH < 1 || PORT_WIDTH > 32) begin : g_bad_width
        $error("PORT_WIDTH must be 1 to 32");
    end

    logic [7:0] one_ctl_r;
    logic [7:0] two_ctl_r;
    logic [5:0] shared_r;
    logic tick_r;
    logic tick_fall;
    logic res1;
    logic res2;
    logic chg1;
    logic chg2;
    logic snap1;
    logic snap2;
    dcc_wr_state_t wr_state_r;
    logic aw_have_r;
    logic w_have_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_go;
    logic rd_go;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;

    // prescaled timer clock edge detection; the latch takes the falling edge
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            tick_r <= 1'b0;
        end else if (CE) begin
            tick_r <= TIMER_TICK;
        end
    end

    assign tick_fall = tick_r && !TIMER_TICK;

    // axi write: address and data taken in either order
    assign wr_go = aw_have_r && w_have_r && wr_state_r == DCC_WR_IDLE;
    assign wr_hit = aw_addr_r == `DCC_ADDR_ONE_CTRL || aw_addr_r == `DCC_ADDR_TWO_CTRL
        || aw_addr_r == `DCC_ADDR_SHARED;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else if (CE) begin
            S_AXI_AWREADY <= !aw_have_r && !S_AXI_AWREADY;
            S_AXI_WREADY <= !w_have_r && !S_AXI_WREADY;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            // both halves leave together once the pair is served
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            wr_state_r <= DCC_WR_IDLE;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `DCC_RESP_OKAY;
        end else if (CE) begin
            case (wr_state_r)
                DCC_WR_IDLE: begin
                    if (wr_go) begin
                        S_AXI_BVALID <= 1'b1;
                        S_AXI_BRESP <= wr_hit ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
                        wr_state_r <= DCC_WR_RESP;
                    end
                end
                DCC_WR_RESP: begin
                    if (S_AXI_BREADY) begin
                        S_AXI_BVALID <= 1'b0;
                        wr_state_r <= DCC_WR_IDLE;
                    end
                end
                default: begin
                    wr_state_r <= DCC_WR_IDLE;
                end
            endcase
        end
    end

    // control registers; only byte lane 0 holds data
    // bit 6 is stored but reads always show the live result there
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            one_ctl_r <= `DCC_CTL_RESET;
            two_ctl_r <= `DCC_CTL_RESET;
            shared_r <= 6'(`DCC_SH_RESET);
        end else if (CE && wr_go && w_strb_r[0]) begin
            if (aw_addr_r == `DCC_ADDR_ONE_CTRL) begin
                one_ctl_r <= w_data_r[7:0];
            end
            if (aw_addr_r == `DCC_ADDR_TWO_CTRL) begin
                two_ctl_r <= w_data_r[7:0];
            end
            if (aw_addr_r == `DCC_ADDR_SHARED) begin
                shared_r <= w_data_r[5:0];
            end
        end
    end

    // axi read: one cycle after the address is taken
    // the answer is registered so it stands unchanged until rready
    assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
    assign rd_hit = S_AXI_ARADDR == `DCC_ADDR_ONE_CTRL || S_AXI_ARADDR == `DCC_ADDR_TWO_CTRL
        || S_AXI_ARADDR == `DCC_ADDR_SHARED || S_AXI_ARADDR == `DCC_ADDR_STATUS;

    always_comb begin
        rd_word = 32'h0;
        case (S_AXI_ARADDR)
            `DCC_ADDR_ONE_CTRL: begin
                rd_word[7:0] = one_ctl_r;
                rd_word[`DCC_CTL_OUTPUT] = res1;
            end
            `DCC_ADDR_TWO_CTRL: begin
                rd_word[7:0] = two_ctl_r;
                rd_word[`DCC_CTL_OUTPUT] = res2;
            end
            `DCC_ADDR_SHARED: begin
                rd_word[5:0] = shared_r;
                rd_word[`DCC_SH_MIRROR1] = res1;
                rd_word[`DCC_SH_MIRROR2] = res2;
            end
            `DCC_ADDR_STATUS: begin
                rd_word[1:0] = {chg2, chg1};
            end
            default: begin
                rd_word = 32'h0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= `DCC_RESP_OKAY;
        end else if (CE) begin
            // ready whenever no answer waits, so a held request is never starved
            S_AXI_ARREADY <= !S_AXI_RVALID;
            if (rd_go) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_word;
                S_AXI_RRESP <= rd_hit ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
                S_AXI_ARREADY <= 1'b0;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // access to a comparator's own control register refreshes its reference
    // latch; shared register reads do not touch it
    assign snap1 = (rd_go && S_AXI_ARADDR == `DCC_ADDR_ONE_CTRL)
        || (wr_go && aw_addr_r == `DCC_ADDR_ONE_CTRL);
    assign snap2 = (rd_go && S_AXI_ARADDR == `DCC_ADDR_TWO_CTRL)
        || (wr_go && aw_addr_r == `DCC_ADDR_TWO_CTRL);

    dcc_cmp_path u_path1 (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .raw_above(CMP1_ABOVE),
        .enable(one_ctl_r[`DCC_CTL_ENABLE]),
        .polarity(one_ctl_r[`DCC_CTL_POLARITY]),
        .sync_mode(shared_r[`DCC_SH_SYNC1]),
        .tick_fall(tick_fall),
        .snap(snap1),
        .result(res1),
        .change(chg1)
    );

    dcc_cmp_path u_path2 (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .raw_above(CMP2_ABOVE),
        .enable(two_ctl_r[`DCC_CTL_ENABLE]),
        .polarity(two_ctl_r[`DCC_CTL_POLARITY]),
        .sync_mode(shared_r[`DCC_SH_SYNC2]),
        .tick_fall(tick_fall),
        .snap(snap2),
        .result(res2),
        .change(chg2)
    );

    // registered analog controls
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            CMP1_ANALOG <= '0;
            CMP2_ANALOG <= '0;
        end else if (CE) begin
            CMP1_ANALOG.enable <= one_ctl_r[`DCC_CTL_ENABLE];
            CMP1_ANALOG.pin_drive <= one_ctl_r[`DCC_CTL_PIN_OE];
            CMP1_ANALOG.speed_high <= one_ctl_r[`DCC_CTL_SPEED];
            CMP1_ANALOG.ref_to_pos <= one_ctl_r[`DCC_CTL_REFSEL];
            CMP1_ANALOG.ref_from_fvr <= shared_r[`DCC_SH_RSRC1];
            CMP1_ANALOG.hysteresis <= shared_r[`DCC_SH_HYS1];
            CMP1_ANALOG.channel <= one_ctl_r[`DCC_CTL_CHAN_HI:`DCC_CTL_CHAN_LO];
            CMP2_ANALOG.enable <= two_ctl_r[`DCC_CTL_ENABLE];
            CMP2_ANALOG.pin_drive <= two_ctl_r[`DCC_CTL_PIN_OE];
            CMP2_ANALOG.speed_high <= two_ctl_r[`DCC_CTL_SPEED];
            CMP2_ANALOG.ref_to_pos <= two_ctl_r[`DCC_CTL_REFSEL];
            CMP2_ANALOG.ref_from_fvr <= shared_r[`DCC_SH_RSRC2];
            CMP2_ANALOG.hysteresis <= shared_r[`DCC_SH_HYS2];
            CMP2_ANALOG.channel <= two_ctl_r[`DCC_CTL_CHAN_HI:`DCC_CTL_CHAN_LO];
        end
    end

    // registered pin level and pin drive; oe low while the pin is driven
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            CMP1_PIN <= 1'b0;
            CMP2_PIN <= 1'b0;
            CMP1_PIN_OE_B <= 1'b1;
            CMP2_PIN_OE_B <= 1'b1;
        end else if (CE) begin
            CMP1_PIN <= res1;
            CMP2_PIN <= res2;
            CMP1_PIN_OE_B <= !(one_ctl_r[`DCC_CTL_PIN_OE] && one_ctl_r[`DCC_CTL_ENABLE]
                && !CMP1_PORT_DIRECTION);
            CMP2_PIN_OE_B <= !(two_ctl_r[`DCC_CTL_PIN_OE] && two_ctl_r[`DCC_CTL_ENABLE]
                && !CMP2_PORT_DIRECTION);
        end
    end

    // mismatch levels handed to the interrupt logic outside
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            CMP1_CHANGE <= 1'b0;
            CMP2_CHANGE <= 1'b0;
        end else if (CE) begin
            CMP1_CHANGE <= chg1;
            CMP2_CHANGE <= chg2;
        end
    end

    // port read value: analog pins read as zero, one bit per pin
    for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_port
        always_ff @(posedge CLK) begin
            if (!RST_B) begin
                PORT_READ[i] <= 1'b0;
            end else if (CE) begin
                PORT_READ[i] <= PORT_ANALOG[i] ? 1'b0 : PORT_PINS[i];
            end
        end
    end
endmodule : dcc_top

// >>> dv/dcc_monitor.sv
// protocol and pin checks seen from the top ports only
module dcc_monitor
    import dcc_pkg::*;
#(
    parameter int PORT_WIDTH = 8
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CMP1_PORT_DIRECTION,
    input wire logic CMP2_PORT_DIRECTION,
    input wire logic [PORT_WIDTH-1:0] PORT_PINS,
    input wire logic [PORT_WIDTH-1:0] PORT_ANALOG,
    input wire logic [PORT_WIDTH-1:0] PORT_READ,
    input wire dcc_analog_t CMP2_ANALOG,
    input wire logic CMP1_PIN_OE_B,
    input wire logic CMP2_PIN_OE_B,
    input wire logic CMP2_CHANGE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // bus answers stay until taken
    resp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped early");
    read_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped early");
    rdata_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
    // state right after reset release
    reset_state_a: assert property ($rose(RST_B) |-> CMP2_ANALOG == 8'h00 && CMP2_PIN_OE_B && !S_AXI_BVALID)
        else $error("not idle after reset");
    speed_reset_a: assert property ($rose(RST_B) |-> ##1 CMP2_ANALOG.speed_high)
        else $error("speed select not high after reset");
    // port reads and pin drive
    port_zero_a: assert property ($past(CE) && $past(RST_B) |-> PORT_READ == ($past(PORT_PINS) & ~$past(PORT_ANALOG)))
        else $error("analog pin not read as zero");
    dir_one_off_a: assert property ($past(CE) && $past(RST_B) && $past(CMP1_PORT_DIRECTION) |-> CMP1_PIN_OE_B)
        else $error("pin one driven while input");
    dir_two_off_a: assert property ($past(CE) && $past(RST_B) && $past(CMP2_PORT_DIRECTION) |-> CMP2_PIN_OE_B)
        else $error("pin two driven while input");
    drive_en_a: assert property (!CMP2_PIN_OE_B |-> CMP2_ANALOG.enable && CMP2_ANALOG.pin_drive)
        else $error("pin two driven while off");
    cover property (S_AXI_BVALID && S_AXI_BREADY);
    cover property ($rose(CMP2_CHANGE));
    cover property (!CMP2_PIN_OE_B);
endmodule : dcc_monitor
bind dcc_top dcc_monitor #(.PORT_WIDTH(PORT_WIDTH)) u_dcc_monitor (.*);

// >>> dv/tb.sv
`include "dcc_cfg.svh"
module tb
    import dcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0, RST_B = 1'b0, CE = 1'b1, CMP1_ABOVE = 1'b0, CMP2_ABOVE = 1'b0, TIMER_TICK = 1'b0;
    logic CMP1_PORT_DIRECTION = 1'b0, CMP2_PORT_DIRECTION = 1'b0;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hf;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
    logic [7:0] PORT_PINS = 8'h00, PORT_ANALOG = 8'h00, PORT_READ;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    dcc_analog_t CMP1_ANALOG, CMP2_ANALOG;
    logic CMP1_PIN, CMP1_PIN_OE_B, CMP2_PIN, CMP2_PIN_OE_B, CMP1_CHANGE, CMP2_CHANGE, o1, o2;
    int bad_count = 0, checked = 0, i, n, c1, c2, sh;

    dcc_top #(.PORT_WIDTH(8)) u_dcc_top (.*);

    // free-running clock
    initial begin
        forever #5 CLK = ~CLK;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    task automatic cyc(input int k);
        repeat (k) @(posedge CLK);
    endtask : cyc
    // write one byte register, address and data offered together
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h0, d};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID) begin
                S_AXI_BREADY <= 1'b0;
                chk(S_AXI_BRESP, `DCC_RESP_OKAY);
                return;
            end
        end
        bad_count++;
        final_report();
    endtask : wr
    // read and compare the masked word
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID) begin
                S_AXI_RREADY <= 1'b0;
                chk(S_AXI_RDATA & m, exp);
                chk(S_AXI_RRESP, a[1:0] != 2'b00 ? `DCC_RESP_SLVERR : `DCC_RESP_OKAY);
                return;
            end
        end
        bad_count++;
        final_report();
    endtask : rdc
    function automatic logic exp_out(input int c, input logic above);
        return c[7] ? (above ^ c[4]) : c[4];
    endfunction : exp_out
    task automatic reset_chk();
        RST_B <= 1'b0;
        cyc(6);
        RST_B <= 1'b1;
        cyc(2);
        rdc(`DCC_ADDR_TWO_CTRL, 32'h08, 32'hffffffff);
        rdc(`DCC_ADDR_ONE_CTRL, 32'h08, 32'hffffffff);
        rdc(`DCC_ADDR_SHARED, 32'h00, 32'hffffffff);
        rdc(4'h2, 32'h0, 32'hffffff00);
        $display("test reset done");
    endtask : reset_chk

    // main sequence
    initial begin
        void'($urandom(32'h09460eef));
        reset_chk();
        for (i = 0; i < 16; i++) begin
            c1 = $urandom & 8'hbf;
            c2 = $urandom & 8'hbf;
            sh = $urandom & 8'h3c;
            CMP1_ABOVE <= 1'($urandom);
            CMP2_ABOVE <= 1'($urandom);
            CMP1_PORT_DIRECTION <= 1'($urandom);
            CMP2_PORT_DIRECTION <= 1'($urandom);
            PORT_PINS <= 8'($urandom);
            PORT_ANALOG <= 8'($urandom);
            wr(`DCC_ADDR_ONE_CTRL, 8'(c1));
            wr(`DCC_ADDR_TWO_CTRL, 8'(c2));
            wr(`DCC_ADDR_SHARED, 8'(sh));
            cyc(3);
            o1 = exp_out(c1, CMP1_ABOVE);
            o2 = exp_out(c2, CMP2_ABOVE);
            chk(PORT_READ, PORT_PINS & ~PORT_ANALOG);
            chk({CMP2_ANALOG.enable, CMP2_ANALOG.speed_high, CMP2_ANALOG.ref_to_pos, CMP2_ANALOG.channel},
                {c2[7], c2[3], c2[2], c2[1:0]});
            chk({CMP1_ANALOG.ref_from_fvr, CMP2_ANALOG.ref_from_fvr, CMP1_ANALOG.hysteresis, CMP2_ANALOG.hysteresis},
                sh[5:2]);
            chk(CMP2_PIN_OE_B, !(c2[5] && c2[7] && !CMP2_PORT_DIRECTION));
            chk(CMP1_PIN_OE_B, !(c1[5] && c1[7] && !CMP1_PORT_DIRECTION));
            if (!CMP2_PIN_OE_B) chk(CMP2_PIN, o2);
            chk({CMP1_PIN, CMP2_PIN}, {o1, o2});
            chk(CMP1_ANALOG, {c1[7], c1[5], c1[3], c1[2], sh[5], sh[3], c1[1:0]});
            chk(CMP2_ANALOG.pin_drive, c2[5]);
            rdc(`DCC_ADDR_TWO_CTRL, {c2[7], o2, c2[5:0]}, 32'hffffffff);
            rdc(`DCC_ADDR_SHARED, {o1, o2, sh[5:0]}, 32'hffffffff);
            rdc(`DCC_ADDR_ONE_CTRL, {c1[7], o1, c1[5:0]}, 32'hffffffff);
            cyc(2);
            chk(CMP1_CHANGE, 1'b0);
        end
        $display("test random done");
        // sync mode holds until the tick falls
        CMP2_ABOVE <= 1'b0;
        TIMER_TICK <= 1'b1;
        wr(`DCC_ADDR_TWO_CTRL, 8'h80);
        wr(`DCC_ADDR_SHARED, 8'h01);
        TIMER_TICK <= 1'b0;
        cyc(2);
        TIMER_TICK <= 1'b1;
        CMP2_ABOVE <= 1'b1;
        cyc(4);
        rdc(`DCC_ADDR_TWO_CTRL, 32'h80, 32'hffffffff);
        TIMER_TICK <= 1'b0;
        cyc(3);
        rdc(`DCC_ADDR_TWO_CTRL, 32'hc0, 32'hffffffff);
        wr(`DCC_ADDR_SHARED, 8'h00);
        CMP2_ABOVE <= 1'b0;
        cyc(3);
        rdc(`DCC_ADDR_TWO_CTRL, 32'h80, 32'hffffffff);
        $display("test sync done");
        // mismatch flag set by change, kept by shared read, cleared by control read
        cyc(3);
        chk(CMP2_CHANGE, 1'b0);
        CMP2_ABOVE <= 1'b1;
        cyc(3);
        chk(CMP2_CHANGE, 1'b1);
        rdc(`DCC_ADDR_SHARED, 32'h40, 32'h40);
        cyc(2);
        chk(CMP2_CHANGE, 1'b1);
        rdc(`DCC_ADDR_STATUS, 32'h2, 32'hffffffff);
        rdc(`DCC_ADDR_TWO_CTRL, 32'hc0, 32'hffffffff);
        cyc(3);
        chk(CMP2_CHANGE, 1'b0);
        S_AXI_WSTRB <= 4'he;
        wr(`DCC_ADDR_TWO_CTRL, 8'h00);
        S_AXI_WSTRB <= 4'hf;
        rdc(`DCC_ADDR_TWO_CTRL, 32'hc0, 32'hffffffff);
        $display("test change done");
        reset_chk();
        final_report();
    end
endmodule : tb
